// ---- src/dco_pkg.sv ----
`default_nettype none
package dco_pkg;
    localparam int FEAT_W = 8;
    localparam int CAP_W = 48;
    localparam int MASK_W = 32;
    localparam int DMA_W = 8;
    localparam logic [FEAT_W-1:0] SUB_RESTORE = 8'hC0;
    localparam logic [FEAT_W-1:0] SUB_FREEZE = 8'hC1;
    localparam logic [FEAT_W-1:0] SUB_IDENTIFY = 8'hC2;
    localparam logic [FEAT_W-1:0] SUB_SET = 8'hC3;
    localparam int BIT_HPA = 0;
    localparam int BIT_PUIS = 1;
    localparam int BIT_SEC = 2;
    localparam int BIT_SMART = 3;
    localparam logic [CAP_W-1:0] CAP_28_MAX = 48'h000FFFFFFF;
    localparam logic [MASK_W-1:0] MASK_ALL = 32'hFFFFFFFF;
    localparam logic [DMA_W-1:0] DMA_ALL = 8'hFF;
    localparam logic [1:0] W7_SMART_BITS = 2'h3;

    typedef enum logic [1:0] {
        factory_state,
        reduced_state,
        locked_state,
        boot_state
    } dco_state_e;

    // Settings that a set request carries and that the overlay record keeps.
    typedef struct packed {
        logic [CAP_W-1:0] max_cap;
        logic [MASK_W-1:0] feat_mask;
        logic [DMA_W-1:0] mwdma_mask;
        logic [DMA_W-1:0] udma_mask;
    } dco_cfg_s;

    // Live device conditions that decide validity.
    typedef struct packed {
        logic hpa_28;
        logic hpa_48;
        logic puis_jumper;
        logic sec_enabled;
        logic smart_enabled;
        logic [1:0] word7_bits;
        logic [DMA_W-1:0] mwdma_sel;
        logic [DMA_W-1:0] udma_sel;
    } dco_cond_s;

    typedef struct packed {
        logic valid;
        logic [FEAT_W-1:0] feature;
        dco_cfg_s cfg;
    } dco_cmd_s;

    typedef struct packed {
        logic done;
        logic aborted;
        logic ident_data;
    } dco_resp_s;
endpackage
`default_nettype wire

// ---- src/dco_overlay_fsm.sv ----
`default_nettype none
module dco_overlay_fsm (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic power_on,
    input wire dco_pkg::dco_cfg_s factory_cfg,
    input wire logic nv_present,
    input wire dco_pkg::dco_cfg_s nv_cfg,
    input wire logic nv_ready,
    input wire dco_pkg::dco_cond_s cond,
    input wire dco_pkg::dco_cmd_s cmd,
    output logic cmd_ready,
    output dco_pkg::dco_resp_s resp,
    output logic nv_write,
    output logic nv_store_present,
    output dco_pkg::dco_cfg_s nv_store_cfg,
    output dco_pkg::dco_cfg_s active_cfg,
    output logic [dco_pkg::CAP_W-1:0] native_max_48,
    output logic [dco_pkg::CAP_W-1:0] native_max_28,
    output logic frozen_overlay,
    output dco_pkg::dco_state_e state_out
);
    import dco_pkg::*;

    dco_state_e state_reg;
    logic frozen_reg;
    dco_cfg_s active_reg;
    logic [1:0] pwr_sync;
    logic pwr_prev_reg;
    logic power_start;
    logic [1:0] nvr_sync;

    logic is_restore;
    logic is_freeze;
    logic is_ident;
    logic is_set;
    logic any_hpa;
    logic set_invalid;
    logic restore_invalid;
    logic cap_below;

    // Power-on comes from the supply monitor, so it is synchronised first.
    always_ff @(posedge mclk) begin
        pwr_sync <= {pwr_sync[0], power_on};
        nvr_sync <= {nvr_sync[0], nv_ready};
        pwr_prev_reg <= pwr_sync[1];
    end

    assign power_start = pwr_sync[1] & ~pwr_prev_reg;

    assign is_restore = cmd.feature == SUB_RESTORE;
    assign is_freeze = cmd.feature == SUB_FREEZE;
    assign is_ident = cmd.feature == SUB_IDENTIFY;
    assign is_set = cmd.feature == SUB_SET;
    assign any_hpa = cond.hpa_28 | cond.hpa_48;
    assign cap_below = cmd.cfg.max_cap < factory_cfg.max_cap;

    always_comb begin
        set_invalid = 1'b0;
        if (cmd.cfg.max_cap != active_reg.max_cap && any_hpa) begin
            set_invalid = 1'b1;
        end
        if (cap_below && cond.hpa_28) begin
            set_invalid = 1'b1;
        end
        if (cmd.cfg.max_cap > factory_cfg.max_cap) begin
            set_invalid = 1'b1;
        end
        if ((cmd.cfg.feat_mask & ~factory_cfg.feat_mask) != '0 ||
            (cmd.cfg.mwdma_mask & ~factory_cfg.mwdma_mask) != '0 ||
            (cmd.cfg.udma_mask & ~factory_cfg.udma_mask) != '0) begin
            set_invalid = 1'b1;
        end
        // A selected mode implies every lower mode stays needed.
        for (int i = 0; i < DMA_W; i++) begin
            // A shift keeps the selected-or-higher test free of a
            // part-select whose bounds move with the loop index.
            if (!cmd.cfg.mwdma_mask[i] && (cond.mwdma_sel >> i) != '0)
                set_invalid = 1'b1;
            if (!cmd.cfg.udma_mask[i] && (cond.udma_sel >> i) != '0)
                set_invalid = 1'b1;
        end
        if (!cmd.cfg.feat_mask[BIT_HPA] && any_hpa) begin
            set_invalid = 1'b1;
        end
        if (!cmd.cfg.feat_mask[BIT_PUIS] && cond.puis_jumper) begin
            set_invalid = 1'b1;
        end
        if (!cmd.cfg.feat_mask[BIT_SEC] && cond.sec_enabled) begin
            set_invalid = 1'b1;
        end
        if (!cmd.cfg.feat_mask[BIT_SMART] &&
            (cond.smart_enabled || (cond.word7_bits & W7_SMART_BITS) != '0))
        begin
            set_invalid = 1'b1;
        end
    end

    // Restore would raise capacity back, which a protected area forbids.
    assign restore_invalid = (active_reg.max_cap < factory_cfg.max_cap) &&
        (cond.hpa_28 || any_hpa);

    // Frozen is cleared only by power-up, never by reset_n.
    always_ff @(posedge mclk) begin
        if (power_start) begin
            frozen_reg <= 1'b0;
        end else if (cmd.valid && cmd_ready && is_freeze &&
                     state_reg != locked_state && state_reg != boot_state) begin
            frozen_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n && !power_start) begin
            resp <= '0;
        end else begin
            resp <= '0;
            if (cmd.valid && cmd_ready && state_reg != boot_state) begin
                resp.done <= 1'b1;
                case (state_reg)
                    factory_state: begin
                        if (is_freeze || is_ident) begin
                            resp.ident_data <= is_ident;
                        end else if (is_set && !set_invalid) begin
                            resp.aborted <= 1'b0;
                        end else begin
                            resp.aborted <= 1'b1;
                        end
                    end
                    reduced_state: begin
                        if (is_freeze || is_ident) begin
                            resp.ident_data <= is_ident;
                        end else if (is_restore && !restore_invalid) begin
                            resp.aborted <= 1'b0;
                        end else begin
                            resp.aborted <= 1'b1;
                        end
                    end
                    default: begin
                        resp.aborted <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Reset leaves overlay state alone; only power-up reloads the record.
    always_ff @(posedge mclk) begin
        nv_write <= 1'b0;
        if (power_start) begin
            state_reg <= boot_state;
        end else if (state_reg == boot_state) begin
            if (nvr_sync[1]) begin
                state_reg <= nv_present ? reduced_state : factory_state;
                active_reg <= nv_present ? nv_cfg : factory_cfg;
            end
        end else if (cmd.valid && cmd_ready) begin
            case (state_reg)
                factory_state: begin
                    if (is_freeze) begin
                        state_reg <= locked_state;
                    end else if (is_set && !set_invalid) begin
                        state_reg <= reduced_state;
                        active_reg <= cmd.cfg;
                        nv_write <= 1'b1;
                        nv_store_present <= 1'b1;
                        nv_store_cfg <= cmd.cfg;
                    end
                end
                reduced_state: begin
                    if (is_freeze) begin
                        state_reg <= locked_state;
                    end else if (is_restore && !restore_invalid) begin
                        state_reg <= factory_state;
                        active_reg <= factory_cfg;
                        nv_write <= 1'b1;
                        nv_store_present <= 1'b0;
                        nv_store_cfg <= factory_cfg;
                    end
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cmd_ready <= 1'b0;
        end else begin
            cmd_ready <= state_reg != boot_state && !cmd_ready;
        end
    end

    // Exported configuration gates identify words and command decode.
    always_ff @(posedge mclk) begin
        active_cfg <= active_reg;
        native_max_48 <= active_reg.max_cap;
        native_max_28 <= (active_reg.max_cap > CAP_28_MAX) ?
            CAP_28_MAX : active_reg.max_cap;
        frozen_overlay <= frozen_reg;
        state_out <= state_reg;
    end
endmodule
`default_nettype wire

// ---- testbench/dco_overlay_fsm_asserts.sv ----
`default_nettype none
module dco_overlay_fsm_asserts (
    input wire logic mclk,
    input wire logic reset_n,
    input wire dco_pkg::dco_cmd_s cmd,
    input wire logic cmd_ready,
    input wire dco_pkg::dco_resp_s resp,
    input wire logic nv_write,
    input wire dco_pkg::dco_cfg_s active_cfg,
    input wire logic [dco_pkg::CAP_W-1:0] native_max_48,
    input wire dco_pkg::dco_state_e state_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import dco_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic tk;
    assign tk = cmd.valid && cmd_ready && state_out != boot_state;
    AST_DONE: assert property (tk |=> resp.done)
        else $error("taken command got no answer");
    AST_LOCK_AB: assert property (tk && state_out == locked_state
        |=> resp.aborted) else $error("locked command not aborted");
    AST_LOCK_KEEP: assert property (state_out == locked_state
        |=> state_out inside {locked_state, boot_state})
        else $error("left locked state without power cycle");
    AST_LOCK_ENTRY: assert property (state_out == locked_state &&
        $past(state_out) != locked_state |-> $past(resp.done) &&
        !$past(resp.aborted)) else $error("locked without freeze");
    AST_FREEZE_OK: assert property (tk && cmd.feature == SUB_FREEZE &&
        state_out inside {factory_state, reduced_state}
        |=> resp.done && !resp.aborted ##1 state_out == locked_state)
        else $error("freeze lock did not succeed");
    AST_FACT_RST: assert property (tk && state_out == factory_state &&
        cmd.feature == SUB_RESTORE
        |=> resp.aborted ##1 state_out == factory_state)
        else $error("restore in factory state not aborted");
    AST_RED_SET: assert property (tk && state_out == reduced_state &&
        cmd.feature == SUB_SET
        |=> resp.aborted ##1 state_out == reduced_state)
        else $error("second set not aborted");
    AST_NATIVE: assert property (state_out != boot_state &&
        state_out != locked_state |-> native_max_48 == active_cfg.max_cap)
        else $error("native max differs from active capacity");
    AST_NVW: assert property (nv_write |-> resp.done && !resp.aborted)
        else $error("record written without a successful command");
    AST_LOCK_CFG: assert property (state_out == locked_state &&
        $past(state_out) == locked_state |-> $stable(active_cfg))
        else $error("configuration changed while locked");
endmodule
bind dco_overlay_fsm dco_overlay_fsm_asserts chk (.mclk(mclk),
    .reset_n(reset_n), .cmd(cmd), .cmd_ready(cmd_ready), .resp(resp),
    .nv_write(nv_write), .active_cfg(active_cfg),
    .native_max_48(native_max_48), .state_out(state_out));
`default_nettype wire

// ---- testbench/dco_host_model.sv ----
`default_nettype none
module dco_host_model (
    input wire logic mclk,
    input wire logic go,
    input wire logic [dco_pkg::FEAT_W-1:0] feat,
    input wire dco_pkg::dco_cfg_s cfg,
    input wire logic cmd_ready,
    output dco_pkg::dco_cmd_s cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    import dco_pkg::*;
    initial cmd = '0;
    // Inverting on release drops valid and keeps stale fields from passing.
    always @(posedge mclk) begin
        if (cmd.valid && cmd_ready) begin
            cmd <= ~cmd;
        end else if (go && !cmd.valid) begin
            cmd <= '{1'b1, feat, cfg};
        end
    end
endmodule
`default_nettype wire

// ---- testbench/config_overlay_state_machine_test.sv ----
`default_nettype none
module config_overlay_state_machine_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dco_pkg::*;
    localparam logic [CAP_W-1:0] FCAP = 48'h000020000000;
    logic mclk, reset_n, power_on, nv_ready, go, nvp, cmd_ready, nv_write;
    logic nsp, frz;
    logic [FEAT_W-1:0] feat;
    logic [FEAT_W-1:0] subs [4];
    logic [CAP_W-1:0] nm48, nm28;
    dco_cfg_s fcfg, cfg, nvc, nsc, acfg, rc;
    dco_cond_s cond;
    dco_cmd_s cmd;
    dco_resp_s resp;
    dco_state_e st;
    logic [1:0] q [$];
    int n_mismatch = 0;
    int n_compared = 0;
    dco_host_model host (.mclk(mclk), .go(go), .feat(feat), .cfg(cfg),
        .cmd_ready(cmd_ready), .cmd(cmd));
    dco_overlay_fsm DUT (.mclk(mclk), .reset_n(reset_n), .power_on(power_on),
        .factory_cfg(fcfg), .nv_present(nvp), .nv_cfg(nvc),
        .nv_ready(nv_ready), .cond(cond), .cmd(cmd), .cmd_ready(cmd_ready),
        .resp(resp), .nv_write(nv_write), .nv_store_present(nsp),
        .nv_store_cfg(nsc), .active_cfg(acfg), .native_max_48(nm48),
        .native_max_28(nm28), .frozen_overlay(frz), .state_out(st));
    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Expected {aborted, ident_data} is queued before the request goes out.
    task automatic cmdx(input logic [7:0] f, input dco_cfg_s c,
        input logic [1:0] e);
        q.push_back(e);
        @(posedge mclk);
        feat <= f;
        cfg <= c;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        for (int i = 0; i < 20 && cmd.valid !== 1'b0; i++) @(negedge mclk);
        repeat (4) @(posedge mclk);
    endtask
    task automatic pwr();
        @(posedge mclk);
        power_on <= 1'b0;
        repeat (4) @(posedge mclk);
        power_on <= 1'b1;
        repeat (5) @(posedge mclk);
        for (int i = 0; i < 50 && st === boot_state; i++) @(negedge mclk);
        repeat (2) @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        if (nv_write === 1'b1) begin
            nvp <= nsp;
            nvc <= nsc;
        end
        if (resp.done === 1'b1) begin
            if (q.size() == 0) chk(1, 0);
            else chk({resp.aborted, resp.ident_data}, q.pop_front());
        end
    end
    initial begin
        #50us;
        n_mismatch++;
        end_sim();
    end
    initial begin
        reset_n = 0; power_on = 0; nv_ready = 1; go = 0; nvp = 0;
        feat = '0; cond = '0;
        subs = '{SUB_RESTORE, SUB_FREEZE, SUB_IDENTIFY, SUB_SET};
        fcfg = '{FCAP, MASK_ALL, DMA_ALL, DMA_ALL};
        cfg = fcfg; nvc = fcfg;
        void'($urandom(32'h4292054B));
        repeat (4) @(posedge mclk);
        pwr();
        reset_n <= 1'b1;
        chk(st, factory_state);
        chk(frz, 0);
        cmdx(SUB_RESTORE, fcfg, 2'b10);
        cmdx(SUB_IDENTIFY, fcfg, 2'b01);
        rc = '{FCAP - 48'h1 - 48'($urandom_range(999)), 32'hFFFFFFF0,
            DMA_ALL, 8'h03};
        for (int k = 0; k < 8; k++) begin
            cond <= dco_cond_s'(k < 7 ? 23'h1 << (22 - k) : 23'h4);
            cmdx(SUB_SET, rc, 2'b10);
        end
        cond <= '0;
        cmdx(SUB_SET, rc, 2'b00);
        chk(st, reduced_state);
        chk(nm48, rc.max_cap);
        chk(nm28, CAP_28_MAX);
        chk(acfg.feat_mask, rc.feat_mask);
        chk(acfg.udma_mask, rc.udma_mask);
        $display("factory state test done");
        cmdx(SUB_SET, rc, 2'b10);
        cond.hpa_28 <= 1'b1;
        cmdx(SUB_RESTORE, fcfg, 2'b10);
        cond <= '0;
        pwr();
        chk(st, reduced_state);
        chk(nm48, rc.max_cap);
        cmdx(SUB_RESTORE, fcfg, 2'b00);
        chk(st, factory_state);
        chk(nm48, FCAP);
        $display("reduced state test done");
        cmdx(SUB_FREEZE, fcfg, 2'b00);
        chk(frz, 1);
        for (int k = 0; k < 4; k++) cmdx(subs[k], rc, 2'b10);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        chk(frz, 1);
        chk(st, locked_state);
        pwr();
        chk(frz, 0);
        chk(st, factory_state);
        $display("locked state test done");
        chk(q.size(), 0);
        end_sim();
    end
endmodule
`default_nettype wire
